//--- fcs_pkg.sv
// package: constants for the flash command host controller
package fcs_pkg;
    // ==================================================
    // command codes
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_IDENT = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
    localparam logic [7:0] CMD_WRITE_SETUP_ALT = 8'h10;
    // ==================================================
    // identifier addresses
    localparam logic [19:0] IDENT_MFR_ADDR = 20'h00000;
    localparam logic [19:0] IDENT_DEV_ADDR = 20'h00001;
    // ==================================================
    // status bit positions
    localparam int SR_READY = 7;
    localparam int SR_SUSPEND = 6;
    localparam int SR_ERASE_ERR = 5;
    localparam int SR_WRITE_ERR = 4;
    localparam int SR_SUPPLY_LOW = 3;
    localparam logic [7:0] SR_VALID_MASK = 8'hf8;
    // ==================================================
    // controller register offsets (byte addresses)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_DATA = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hc;
    // ctrl fields
    localparam int CTRL_GO = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_OP_W = 3;
    localparam int CTRL_PWR = 4;
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_WRITE1 = 3'h1;
    localparam logic [2:0] OP_WRITE2 = 3'h2;
    localparam logic [2:0] OP_STATUS = 3'h3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0010;
    // ==================================================
    // bus timing: 40 MHz
    localparam int CLK_NS = 25;
    localparam int STROBE_NS = 100;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_NS = 50;
    localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
    // ==================================================
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_GAP
    } fcs_state_t;
endpackage : fcs_pkg

//--- fcs_timer.sv
// module: down counter that times the strobe phases
`timescale 1ns/1ps
module fcs_timer #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic done
);
    logic [W-1:0] left;

    always_ff @(posedge clk) begin
        if (rst) begin
            left <= '0;
        end else if (load) begin
            left <= count;
        end else if (left != '0) begin
            left <= left - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || load) begin
            done <= 1'b0;
        end else begin
            done <= (left == {{(W-1){1'b0}}, 1'b1});
        end
    end
endmodule : fcs_timer

//--- fcs_host.sv
// module: wishbone-driven host controller for a byte-wide command flash
// ==================================================
// Functional notes
// [RULE1] either write-setup code is accepted alike; host sends the one software gives
// [RULE2] host sends only defined command codes; others are refused
// [RULE3] after identifier command, address 0 reads maker, address 1 device
// [RULE4] identifier mode lasts until another valid command is written
// [RULE5] identifier reads need no high programming supply
// [RULE6] write and erase need high supply; read-mode commands work at either
// [RULE7] command interface has no address; it latches command, address, data
// [RULE8] erase cycles carry block address; write cycles carry target address
// [RULE9] write occurs on write strobe low with chip select low; rising edge latches
// [RULE10] device starts in array read after power-up or power-down exit
// [RULE11] array read command ignored while engine busy
// [RULE12] after read-status command every read returns status
// [RULE13] status latched on later falling enable; host raises one between reads
// [RULE14] error bits sticky until clear-status command
// [RULE15] host clears supply fault bit before next write or erase
// [RULE16] clear-status resets error bits at either supply level
// [RULE17] status: 7 ready, 6 suspended, 5 erase err, 4 write err, 3 supply low
// [RULE18] non-confirm after erase setup sets both error bits
// [RULE19] erase second cycle is confirm code at block address
// [RULE20] after complete erase or write sequence reads return status
// [RULE21] ready/busy pin low while engine runs
`timescale 1ns/1ps
module fcs_host (
    input wire logic clk,
    input wire logic rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // flash pins
    output logic [19:0] flash_addr,
    input wire logic [7:0] flash_dq_i,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe_n,
    output logic chip_sel_n,
    output logic out_en_n,
    output logic write_en_n,
    output logic power_down_n,
    input wire logic ready_busy_out
);
    fcs_pkg::fcs_state_t state;
    logic [31:0] ctrl;
    logic [19:0] addr_reg;
    logic [7:0] data_reg;
    logic [7:0] rd_data;
    logic [7:0] last_cmd;
    logic busy;
    logic refused;
    logic is_write;
    logic timer_load;
    logic [3:0] timer_count;
    logic timer_done;
    logic wb_hit;
    logic go_req;
    logic go_start;
    logic cmd_refused;
    logic supply_fault;
    logic [2:0] run_op;
    logic [31:0] stat_word;

    // ==================================================
    // command decode used by bus and sequencer
    function automatic logic cmd_defined(input logic [7:0] c);
        cmd_defined = (c == fcs_pkg::CMD_READ_ARRAY) || (c == fcs_pkg::CMD_IDENT)
            || (c == fcs_pkg::CMD_READ_STATUS) || (c == fcs_pkg::CMD_CLEAR_STATUS)
            || (c == fcs_pkg::CMD_ERASE_SETUP) || (c == fcs_pkg::CMD_ERASE_CONFIRM)
            || (c == fcs_pkg::CMD_WRITE_SETUP) || (c == fcs_pkg::CMD_WRITE_SETUP_ALT)
            || (c == 8'hb0);
    endfunction : cmd_defined

    function automatic logic is_setup(input logic [7:0] c);
        is_setup = (c == fcs_pkg::CMD_WRITE_SETUP) || (c == fcs_pkg::CMD_WRITE_SETUP_ALT) // [RULE1]
            || (c == fcs_pkg::CMD_ERASE_SETUP);
    endfunction : is_setup

    function automatic logic [2:0] op_field(input logic [31:0] w);
        op_field = w[fcs_pkg::CTRL_OP_LSB +: fcs_pkg::CTRL_OP_W];
    endfunction : op_field

    // ==================================================
    // bus slave
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // first cycle of a sequence must be a defined command; the second carries data
    assign go_req = wb_hit && wb_we_i && (wb_adr_i == fcs_pkg::REG_CTRL) && wb_sel_i[0]
        && wb_dat_i[fcs_pkg::CTRL_GO] && (state == fcs_pkg::ST_IDLE);
    // refused: undefined command, setup after a seen supply fault, or start in power-down
    assign cmd_refused = !wb_dat_i[fcs_pkg::CTRL_PWR]
        || ((op_field(wb_dat_i) == fcs_pkg::OP_WRITE1) && !cmd_defined(data_reg)) // [RULE2]
        || ((op_field(wb_dat_i) == fcs_pkg::OP_WRITE1) && supply_fault
        && is_setup(data_reg)); // [RULE15]
    assign go_start = go_req && !cmd_refused;
    assign is_write = (run_op != fcs_pkg::OP_READ) && (run_op != fcs_pkg::OP_STATUS);
    // status word: 7:0 last command, 15 pin, 16 busy, 17 refused, 18 fault seen
    assign stat_word = {13'h0, supply_fault, refused, busy, ready_busy_out, 7'h00, last_cmd};

    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_hit;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= fcs_pkg::CTRL_RESET;
            addr_reg <= '0;
            data_reg <= '0;
            refused <= 1'b0;
        end else if (wb_hit && wb_we_i) begin
            if (wb_adr_i == fcs_pkg::REG_CTRL) begin
                if (wb_sel_i[0]) begin
                    // first write cycle: only defined command codes leave the host
                    if (wb_dat_i[fcs_pkg::CTRL_GO] && cmd_refused) begin // [RULE2] [RULE15]
                        refused <= 1'b1;
                        ctrl[7:0] <= {wb_dat_i[7:1], 1'b0};
                    end else begin
                        ctrl[7:0] <= wb_dat_i[7:0];
                        refused <= refused && !wb_dat_i[fcs_pkg::CTRL_GO];
                    end
                end
            end else if (wb_adr_i == fcs_pkg::REG_ADDR) begin
                if (wb_sel_i[0]) addr_reg[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) addr_reg[15:8] <= wb_dat_i[15:8];
                if (wb_sel_i[2]) addr_reg[19:16] <= wb_dat_i[19:16];
            end else if (wb_adr_i == fcs_pkg::REG_DATA) begin
                if (wb_sel_i[0]) data_reg <= wb_dat_i[7:0];
            end
        end
        // engine end clears GO even when a bus write lands on the same edge
        if (!rst && state == fcs_pkg::ST_GAP && timer_done) begin
            ctrl[fcs_pkg::CTRL_GO] <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wb_dat_o <= '0;
        end else if (wb_hit && !wb_we_i) begin
            if (wb_adr_i == fcs_pkg::REG_CTRL) begin
                wb_dat_o <= ctrl;
            end else if (wb_adr_i == fcs_pkg::REG_ADDR) begin
                wb_dat_o <= {12'h000, addr_reg};
            end else if (wb_adr_i == fcs_pkg::REG_DATA) begin
                wb_dat_o <= {24'h000000, rd_data};
            end else if (wb_adr_i == fcs_pkg::REG_STAT) begin
                wb_dat_o <= stat_word;
            end else begin
                wb_dat_o <= '0;
            end
        end
    end

    // ==================================================
    // flash bus sequencer
    // [RULE7] the command interface has no location; any address works for pure commands
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= fcs_pkg::ST_IDLE;
        end else begin
            case (state)
                fcs_pkg::ST_IDLE: begin
                    if (go_start) begin
                        state <= fcs_pkg::ST_SETUP;
                    end
                end
                fcs_pkg::ST_SETUP: state <= fcs_pkg::ST_STROBE;
                fcs_pkg::ST_STROBE: begin
                    if (timer_done) state <= fcs_pkg::ST_HOLD;
                end
                fcs_pkg::ST_HOLD: state <= fcs_pkg::ST_GAP;
                fcs_pkg::ST_GAP: begin
                    if (timer_done) state <= fcs_pkg::ST_IDLE;
                end
                default: state <= fcs_pkg::ST_IDLE;
            endcase
        end
    end

    // op held for the whole access; a CTRL write while busy cannot bend the strobes
    always_ff @(posedge clk) begin
        if (rst) begin
            run_op <= fcs_pkg::OP_READ;
        end else if (go_start) begin
            run_op <= op_field(wb_dat_i);
        end
    end

    assign busy = (state != fcs_pkg::ST_IDLE);
    assign timer_load = (state == fcs_pkg::ST_SETUP) || (state == fcs_pkg::ST_HOLD);
    assign timer_count = (state == fcs_pkg::ST_SETUP) ? 4'(fcs_pkg::STROBE_CYC)
        : 4'(fcs_pkg::GAP_CYC);

    fcs_timer #(.W(4)) u_timer (
        .clk(clk),
        .rst(rst),
        .load(timer_load),
        .count(timer_count),
        .done(timer_done)
    );

    // address and data set up before the strobe, held past its rising edge
    always_ff @(posedge clk) begin
        if (rst) begin
            flash_addr <= '0;
            flash_dq_o <= '0;
        end else if (state == fcs_pkg::ST_IDLE && go_start) begin
            flash_addr <= addr_reg; // [RULE8] [RULE3] [RULE19]
            flash_dq_o <= data_reg; // [RULE19]
        end
    end

    // chip select frames every cycle; write strobe inside it
    always_ff @(posedge clk) begin
        if (rst) begin
            chip_sel_n <= 1'b1;
            write_en_n <= 1'b1;
            out_en_n <= 1'b1;
            flash_dq_oe_n <= 1'b1;
        end else begin
            chip_sel_n <= !(state == fcs_pkg::ST_SETUP || state == fcs_pkg::ST_STROBE
                || state == fcs_pkg::ST_HOLD);
            write_en_n <= !(state == fcs_pkg::ST_STROBE && is_write); // [RULE9]
            out_en_n <= !(state == fcs_pkg::ST_STROBE && !is_write); // [RULE13]
            // data driven from setup through hold so it outlasts the strobe's rise
            flash_dq_oe_n <= !(is_write && (state == fcs_pkg::ST_SETUP
                || state == fcs_pkg::ST_STROBE || state == fcs_pkg::ST_HOLD)); // [RULE9]
        end
    end

    // ==================================================
    // read capture; chip select falls a cycle before output enable, both rise after, so each read
    // gets fresh status
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= '0;
        end else if (state == fcs_pkg::ST_STROBE && !is_write && timer_done) begin
            if (run_op == fcs_pkg::OP_STATUS) begin
                rd_data <= flash_dq_i & fcs_pkg::SR_VALID_MASK; // [RULE13] [RULE17]
            end else begin
                rd_data <= flash_dq_i; // [RULE12] [RULE3]
            end
        end
    end

    // last command byte issued, for software tracking of device mode
    always_ff @(posedge clk) begin
        if (rst) begin
            last_cmd <= fcs_pkg::CMD_READ_ARRAY; // [RULE10]
        end else if (state == fcs_pkg::ST_HOLD && is_write
            && run_op == fcs_pkg::OP_WRITE1) begin
            last_cmd <= flash_dq_o; // [RULE4]
        end
    end

    // power-down pin from software; low resets the device to array read
    always_ff @(posedge clk) begin
        if (rst) begin
            power_down_n <= 1'b1;
        end else begin
            power_down_n <= ctrl[fcs_pkg::CTRL_PWR]; // [RULE10]
        end
    end

    // ==================================================
    // supply fault guard: once a status read shows the fault, setups are refused
    // until a clear-status command goes out or the power-down pin goes low; array-op reads are not inspected
    always_ff @(posedge clk) begin
        if (rst) begin
            supply_fault <= 1'b0;
        end else if (state == fcs_pkg::ST_STROBE && timer_done
            && run_op == fcs_pkg::OP_STATUS && flash_dq_i[fcs_pkg::SR_SUPPLY_LOW]) begin
            supply_fault <= 1'b1; // [RULE15]
        end else if (!power_down_n) begin
            // power-down entry clears the device status, so the guard clears while the pin is low
            supply_fault <= 1'b0;
        end else if (state == fcs_pkg::ST_HOLD && run_op == fcs_pkg::OP_WRITE1
            && flash_dq_o == fcs_pkg::CMD_CLEAR_STATUS) begin
            supply_fault <= 1'b0; // [RULE15]
        end
    end
endmodule : fcs_host

//--- fcs_host_monitor.sv
// checker for the flash host controller's bus and pin timing
`timescale 1ns/1ps
module fcs_host_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [19:0] flash_addr,
    input wire logic [7:0] flash_dq_o,
    input wire logic flash_dq_oe_n,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    input wire logic power_down_n
);
    // ==================================================
    // pin and bus relations
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_we_selected: assert property (!write_en_n |-> !chip_sel_n)
        else $error("write strobe without select");
    a_we_width: assert property ($fell(write_en_n) |=> !write_en_n [*4] ##1 write_en_n)
        else $error("write strobe width wrong");
    a_latch_hold: assert property (!write_en_n |=> $stable(flash_addr) && $stable(flash_dq_o))
        else $error("address or data moved in strobe");
    a_dq_driven: assert property (!write_en_n |-> !flash_dq_oe_n)
        else $error("data not driven in strobe");
    a_no_contend: assert property (!out_en_n |-> flash_dq_oe_n && write_en_n)
        else $error("host drives data in read");
    a_oe_toggle: assert property ($fell(out_en_n) |=> !out_en_n [*4] ##1 out_en_n)
        else $error("read enable width wrong");
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_pd_quiet: assert property (!power_down_n |-> chip_sel_n)
        else $error("access in power down");
endmodule : fcs_host_monitor

bind fcs_host fcs_host_monitor fcs_host_monitor_i (.*);

//--- fcs_flash_model.sv
// behavioural flash device facing the host controller
`timescale 1ns/1ps
module fcs_flash_model #(
    parameter logic [7:0] MFR_CODE = 8'h3c, // arbitrary value
    parameter logic [7:0] DEV_CODE = 8'hc3, // arbitrary value
    parameter int BUSY_NS = 4000
) (
    input wire logic [19:0] flash_addr,
    input wire logic [7:0] flash_dq_o,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    input wire logic power_down_n,
    input wire logic vpp_high,
    output logic [7:0] flash_dq_i,
    output logic ready_busy_out
);
    logic [1:0] mode = 2'd0; // 0 array, 1 ident, 2 status
    logic [1:0] pend = 2'd0;
    logic [7:0] sr = 8'h80;
    logic [7:0] srl = 8'h80;
    logic [7:0] q = 8'h00;
    logic busy = 1'b0;
    logic drv;
    logic [7:0] val;
    // ==================================================
    // command latch, no address of its own
    always @(posedge write_en_n or negedge power_down_n) begin
        if (!power_down_n) begin
            mode = 2'd0;
            pend = 2'd0;
            sr = 8'h80;
        end else if (!chip_sel_n) begin
            if (pend != 2'd0) begin
                mode = 2'd2;
                if (pend == 2'd1 && flash_dq_o != 8'hd0) sr[5:4] = 2'b11;
                else if (!vpp_high) sr[3] = 1'b1;
                else begin
                    busy = 1'b1;
                    busy <= #(BUSY_NS) 1'b0;
                end
                pend = 2'd0;
            end
            else case (flash_dq_o)
                8'hff: if (!busy) mode = 2'd0;
                8'h90: mode = 2'd1;
                8'h70: mode = 2'd2;
                8'h50: sr[5:3] = 3'b000;
                8'h20: pend = 2'd1;
                8'h40, 8'h10: pend = 2'd2;
                default: ;
            endcase
        end
    end
    // ==================================================
    // reserved bits 2:0 driven to 101 so that host masking shows
    always @(negedge out_en_n or negedge chip_sel_n) begin
        if (!out_en_n && !chip_sel_n) srl = {!busy, sr[6:3], 3'b101};
    end
    assign drv = !chip_sel_n && !out_en_n && power_down_n;
    assign val = mode == 2'd2 ? srl : mode == 2'd1 ?
        (flash_addr == '0 ? MFR_CODE : DEV_CODE) : flash_addr[7:0] ^ 8'h5a;
    always @* if (drv) q = val;
    // released bus shows the inverse, never a kind stale value
    assign flash_dq_i = drv ? val : ~q;
    assign ready_busy_out = !busy || !power_down_n;
endmodule : fcs_flash_model

//--- tb_fcs_host.sv
// self-checking bench for the flash command host controller
`timescale 1ns/1ps
`define CHK(a, e) begin \
    n_tests++; \
    if ((a) !== (e)) begin \
        error_cnt++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); \
    end \
end
module tb_fcs_host;
    logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, vpp_high;
    logic flash_dq_oe_n, chip_sel_n, out_en_n, write_en_n, power_down_n, ready_busy_out;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rdat, seed, e, m;
    logic [19:0] flash_addr;
    logic [7:0] flash_dq_i, flash_dq_o;
    logic [31:0] exp_q[$], msk_q[$];
    logic [7:0] wcode[2] = '{8'h40, 8'h10};
    int error_cnt = 0;
    int n_tests = 0;
    fcs_host fcs_host_i (.*);
    // identity codes 3c and c3 are arbitrary
    fcs_flash_model #(.MFR_CODE(8'h3c), .DEV_CODE(8'hc3)) fcs_flash_model_i (.*);
    // ==================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, ev, mv);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= (a == fcs_pkg::REG_DATA) ? 4'h1 : 4'hf;
        wb_dat_i <= d;
        if (!w) begin
            exp_q.push_back(ev & mv);
            msk_q.push_back(mv);
        end
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : bus
    task automatic op(input logic [2:0] o, input logic [19:0] fa, input logic [7:0] d);
        bus(1'b1, fcs_pkg::REG_ADDR, {12'h0, fa}, '0, '0);
        bus(1'b1, fcs_pkg::REG_DATA, {24'h0, d}, '0, '0);
        bus(1'b1, fcs_pkg::REG_CTRL, {27'h0, 1'b1, o, 1'b1}, '0, '0);
        do bus(1'b0, fcs_pkg::REG_CTRL, '0, '0, '0); while (rdat[0] !== 1'b0);
    endtask : op
    task automatic cmd(input logic [7:0] c);
        op(fcs_pkg::OP_WRITE1, 20'h0, c);
    endtask : cmd
    task automatic getb(input logic [2:0] o, input logic [19:0] fa, input logic [7:0] ev, mv);
        op(o, fa, 8'h00);
        bus(1'b0, fcs_pkg::REG_DATA, '0, {24'h0, ev}, {24'h0, mv});
    endtask : getb
    // ==================================================
    // result watcher: oldest note against each read answer
    always @(posedge clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            if (m != '0) `CHK(wb_dat_o & m, e)
        end
    end
    task print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // run needs under 1000 cycles; 8000 allowed
    initial begin
        #200000;
        error_cnt++;
        print_verdict;
    end
    // ==================================================
    // scenarios
    initial begin
        rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, vpp_high} = 4'h0;
        {wb_adr_i, wb_sel_i, wb_dat_i} = 40'h0;
        seed = 32'he126cb8e;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, fcs_pkg::REG_CTRL, '0, fcs_pkg::CTRL_RESET, '1);
        bus(1'b0, fcs_pkg::REG_STAT, '0, 32'h80ff, 32'h3ffff);
        bus(1'b1, 4'h2, 32'h5, '0, '0);
        bus(1'b0, 4'h2, '0, '0, '1);
        cmd(fcs_pkg::CMD_IDENT);
        getb(fcs_pkg::OP_READ, fcs_pkg::IDENT_MFR_ADDR, 8'h3c, 8'hff);
        getb(fcs_pkg::OP_READ, fcs_pkg::IDENT_DEV_ADDR, 8'hc3, 8'hff);
        // power-down exit falls back to array reads
        bus(1'b1, fcs_pkg::REG_CTRL, 32'h1, '0, '0);
        bus(1'b0, fcs_pkg::REG_STAT, '0, 32'h20000, 32'h20000);
        bus(1'b1, fcs_pkg::REG_CTRL, fcs_pkg::CTRL_RESET, '0, '0);
        getb(fcs_pkg::OP_READ, 20'h5, 8'h5f, 8'hff);
        foreach (wcode[i]) begin
            seed = xs(seed);
            op(fcs_pkg::OP_WRITE1, seed[19:0], wcode[i]);
            op(fcs_pkg::OP_WRITE2, seed[19:0], seed[27:20]);
            getb(fcs_pkg::OP_STATUS, seed[19:0], 8'h88, 8'hf8);
            cmd(wcode[i]);
            bus(1'b0, fcs_pkg::REG_STAT, '0, 32'h60000, 32'h60000);
            cmd(fcs_pkg::CMD_CLEAR_STATUS);
            getb(fcs_pkg::OP_READ, 20'h0, 8'h80, 8'hf8);
        end
        cmd(fcs_pkg::CMD_ERASE_SETUP);
        cmd(fcs_pkg::CMD_READ_ARRAY);
        getb(fcs_pkg::OP_READ, 20'h0, 8'hb0, 8'hf8);
        cmd(fcs_pkg::CMD_READ_STATUS);
        getb(fcs_pkg::OP_READ, 20'h3, 8'hb0, 8'hf8);
        cmd(fcs_pkg::CMD_CLEAR_STATUS);
        // erase at high supply, array read ignored while busy
        vpp_high <= 1'b1;
        seed = xs(seed);
        op(fcs_pkg::OP_WRITE1, seed[19:0], fcs_pkg::CMD_ERASE_SETUP);
        op(fcs_pkg::OP_WRITE1, seed[19:0], fcs_pkg::CMD_ERASE_CONFIRM);
        bus(1'b0, fcs_pkg::REG_STAT, '0, '0, 32'h8000);
        cmd(fcs_pkg::CMD_READ_ARRAY);
        getb(fcs_pkg::OP_READ, 20'h0, 8'h00, 8'h80);
        do bus(1'b0, fcs_pkg::REG_STAT, '0, '0, '0); while (rdat[15] !== 1'b1);
        getb(fcs_pkg::OP_READ, 20'h0, 8'h80, 8'hf8);
        cmd(8'h33);
        bus(1'b0, fcs_pkg::REG_STAT, '0, 32'h20000, 32'h60000);
        @(posedge clk);
        print_verdict;
    end
endmodule : tb_fcs_host
